/* hw/tpd_pkg.sv */
// register map, field layout and constants of the touch pattern detector
`default_nettype none
package tpd_pkg;
    localparam int NUM_INPUTS  = 8;
    localparam int THRESH_W    = 7;
    localparam int DELTA_W     = 8;
    localparam int ADDR_W      = 12;
    // register indices; byte address = 4 * index
    localparam logic [7:0] IDX_MAIN_CONTROL   = 8'h00;
    localparam logic [7:0] IDX_GENERAL_STATUS = 8'h02;
    localparam logic [7:0] IDX_PATTERN_CONFIG = 8'h2B;
    localparam logic [7:0] IDX_PATTERN_SELECT = 8'h2D;
    localparam logic [7:0] IDX_BASE_LIMIT     = 8'h2E;
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK       = 8'h41;
    // pattern_detect_config fields
    localparam int CFG_ENABLE_BIT    = 7;
    localparam int CFG_THRESH_LSB    = 2;
    localparam int CFG_COMPARE_BIT   = 1;
    localparam int CFG_ALERT_BIT     = 0;
    // main_control and general_status fields
    localparam int CTRL_INT_BIT      = 0;
    localparam int GSTAT_PATTERN_BIT = 2;
    localparam int GSTAT_BASE_BIT    = 6;
    // irq_status / irq_mask fields
    localparam int IRQ_PATTERN_BIT   = 0;
    localparam int IRQ_BASE_BIT      = 1;
    localparam int IRQ_W             = 2;
    // reset values
    localparam logic [7:0] RST_PATTERN_CONFIG = 8'h00;
    localparam logic [7:0] RST_PATTERN_SELECT = 8'hFF;
    localparam logic [7:0] RST_BASE_LIMIT     = 8'h00;
    localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;
    // threshold scale codes
    localparam logic [1:0] SCALE_12P5 = 2'h0;
    localparam logic [1:0] SCALE_25   = 2'h1;
    localparam logic [1:0] SCALE_37P5 = 2'h2;
    localparam logic [1:0] SCALE_100  = 2'h3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* hw/tpd_popcount.sv */
// population count of a bit vector
`default_nettype none
module tpd_popcount #(
    parameter int N  = 8,
    parameter int CW = 4
) (
    // operand and count
    input  wire logic [N-1:0]  bits,
    output logic      [CW-1:0] count
);
    initial begin
        if ((1 << CW) <= N) $error("count width too small");
    end
    always_comb begin
        count = '0;
        for (int i = 0; i < N; i++) begin
            count = count + CW'(bits[i]);
        end
    end
endmodule
`default_nettype wire

/* hw/tpd_thresh_cmp.sv */
// per-input scaled threshold and hit vector
`default_nettype none
module tpd_thresh_cmp #(
    parameter int N  = 8,
    parameter int TW = 7,
    parameter int DW = 8
) (
    // configuration
    input  wire logic [1:0]      scale_sel,
    input  wire logic            in_standby,
    input  wire logic [N-1:0]    standby_enabled,
    input  wire logic [N*TW-1:0] active_thresh,
    input  wire logic [TW-1:0]   standby_thresh,
    // per-input measurement
    input  wire logic [N*DW-1:0] delta_count,
    input  wire logic [N-1:0]    noise_flag,
    // result
    output logic      [N-1:0]    hit
);
    initial begin
        if (DW <= TW) $error("delta width must exceed threshold width");
    end
    for (genvar i = 0; i < N; i++) begin : g_in
        logic [TW-1:0] base;
        logic [TW+1:0] scaled;
        always_comb begin
            base = (in_standby && standby_enabled[i]) ? standby_thresh
                 : active_thresh[i*TW +: TW];
            case (scale_sel)
                tpd_pkg::SCALE_12P5: scaled = {2'h0, base} >> 3;
                tpd_pkg::SCALE_25:   scaled = {2'h0, base} >> 2;
                tpd_pkg::SCALE_37P5:
                    scaled = ({2'h0, base} + {1'h0, base, 1'h0}) >> 3;
                default:             scaled = {2'h0, base};
            endcase
        end
        assign hit[i] = noise_flag[i]
            || ({{(TW+2){1'b0}}, delta_count[i*DW +: DW]}
                > {{DW{1'b0}}, scaled});
    end
endmodule
`default_nettype wire

/* hw/tpd_top.sv */
// touch pattern detector with AXI4-Lite register slave
// Overview of operation
// - Detection runs only while config bit 7 is 1; config resets 00h.
// - Threshold code gives 12.5, 25, 37.5 or 100 percent of threshold.
// - Scale touch threshold when active, standby threshold in standby for standby-enabled inputs.
// - Count mode: hit count must reach pattern register's bit count.
// - Pattern mode: each selected input must be over threshold or noisy.
// - Criterion uses one sensing cycle's results only.
// - A pattern event blocks all touches and sets the pattern flag.
// - Blocking lasts while the criterion holds, then touches resume.
// - Flag clears only by writing 0 to int bit once condition gone.
// - Alert output asserts on an event only if alert enable is set.
// - Pattern select holds one bit per input, resets to FFh.
// - Read-only per-input flags of out-of-range base count; reset 00h.
// - Any base count out-of-range bit sets the summary status bit.
`default_nettype none
module tpd_top #(
    parameter int N  = tpd_pkg::NUM_INPUTS,
    parameter int TW = tpd_pkg::THRESH_W,
    parameter int DW = tpd_pkg::DELTA_W,
    parameter int AW = tpd_pkg::ADDR_W
) (
    // clock, reset, enable
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            ce,
    // AXI4-Lite write address
    input  wire logic [AW-1:0]   s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [AW-1:0]   s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // sensing front end
    input  wire logic            sense_cycle_done,
    input  wire logic [N*DW-1:0] delta_count,
    input  wire logic [N-1:0]    noise_flag,
    input  wire logic [N*TW-1:0] active_thresh,
    input  wire logic [TW-1:0]   standby_thresh,
    input  wire logic [N-1:0]    standby_enabled,
    input  wire logic            in_standby,
    input  wire logic [N-1:0]    base_count_out_of_range,
    // touch detection path
    input  wire logic [N-1:0]    touch_detect_raw,
    output logic [N-1:0]         touch_detect,
    output logic                 touch_blocked,
    // alert and interrupt
    output logic                 alert_n,
    output logic                 irq
);
    localparam int CW = $clog2(N + 1);

    initial begin
        if (N != 8) $error("register layout serves exactly eight inputs");
        if (AW < 10) $error("address width too small for register map");
    end

    // registers
    logic [7:0]       pattern_detect_config;
    logic [7:0]       pattern_select;
    logic [7:0]       base_count_limit_flags;
    logic             int_bit;
    logic             pattern_event_flag;
    logic [tpd_pkg::IRQ_W-1:0] irq_status;
    logic [tpd_pkg::IRQ_W-1:0] irq_mask;

    // config fields
    logic             pattern_detect_enable;
    logic [1:0]       pattern_threshold_select;
    logic             pattern_compare_mode;
    logic             pattern_alert_enable;
    assign pattern_detect_enable    =
        pattern_detect_config[tpd_pkg::CFG_ENABLE_BIT];
    assign pattern_threshold_select =
        pattern_detect_config[tpd_pkg::CFG_THRESH_LSB +: 2];
    assign pattern_compare_mode     =
        pattern_detect_config[tpd_pkg::CFG_COMPARE_BIT];
    assign pattern_alert_enable     =
        pattern_detect_config[tpd_pkg::CFG_ALERT_BIT];

    // detection datapath
    logic [N-1:0]     hit;
    logic [CW-1:0]    hit_count;
    logic [CW-1:0]    select_count;
    logic             criterion;
    logic             blocked;
    logic             pattern_event;
    logic             base_count_range_summary;
    logic             base_summary_d;

    tpd_thresh_cmp #(.N(N), .TW(TW), .DW(DW)) u_cmp (
        .scale_sel       (pattern_threshold_select),
        .in_standby      (in_standby),
        .standby_enabled (standby_enabled),
        .active_thresh   (active_thresh),
        .standby_thresh  (standby_thresh),
        .delta_count     (delta_count),
        .noise_flag      (noise_flag),
        .hit             (hit)
    );
    tpd_popcount #(.N(N), .CW(CW)) u_pop_hit (.bits(hit), .count(hit_count));
    tpd_popcount #(.N(N), .CW(CW)) u_pop_sel (
        .bits(pattern_select), .count(select_count));

    // criterion from this sensing cycle's hits only
    always_comb begin
        if (pattern_compare_mode) begin
            criterion = (hit & pattern_select)
                == pattern_select;
        end else begin
            criterion = hit_count >= select_count;
        end
    end
    // new event: criterion met at a sensing cycle
    assign pattern_event = ce && sense_cycle_done && pattern_detect_enable
        && criterion && !blocked;
    // blocking, re-evaluated each sensing cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blocked <= 1'b0;
        end else if (ce) begin
            if (!pattern_detect_enable) begin
                blocked <= 1'b0;
            end else if (sense_cycle_done) begin
                blocked <= criterion;
            end
        end
    end
    assign touch_blocked = blocked;
    // gated touch detections
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            touch_detect <= '0;
        end else if (ce) begin
            if (blocked || pattern_event) begin
                touch_detect <= '0;
            end else begin
                touch_detect <= touch_detect_raw;
            end
        end
    end

    // base count out-of-range mirror and summary
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            base_count_limit_flags <= tpd_pkg::RST_BASE_LIMIT;
            base_summary_d         <= 1'b0;
        end else if (ce) begin
            base_count_limit_flags <= base_count_out_of_range;
            base_summary_d         <= base_count_range_summary;
        end
    end
    assign base_count_range_summary = |base_count_limit_flags;
    // AXI4-Lite slave
    logic [AW-1:0]    aw_addr;
    logic             aw_held;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic             w_held;
    logic             do_write;
    logic [7:0]       wr_idx;
    logic [7:0]       rd_idx;
    logic             wr_mapped;
    logic             rd_mapped;
    logic             wr_lane0;
    logic             clear_int_req;
    logic [31:0]      next_rdata;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write      = ce && aw_held && w_held && !s_axi_bvalid;
    assign wr_idx        = aw_addr[9:2];
    assign rd_idx        = s_axi_araddr[9:2];
    assign wr_lane0      = do_write && w_strb[0];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_comb begin
        case (wr_idx)
            tpd_pkg::IDX_MAIN_CONTROL,
            tpd_pkg::IDX_GENERAL_STATUS,
            tpd_pkg::IDX_PATTERN_CONFIG,
            tpd_pkg::IDX_PATTERN_SELECT,
            tpd_pkg::IDX_BASE_LIMIT,
            tpd_pkg::IDX_IRQ_STATUS,
            tpd_pkg::IDX_IRQ_MASK: wr_mapped = (aw_addr[AW-1:10] == '0);
            default:               wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tpd_pkg::RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? tpd_pkg::RESP_OKAY
                                          : tpd_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // writable configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pattern_detect_config <= tpd_pkg::RST_PATTERN_CONFIG;
            pattern_select        <= tpd_pkg::RST_PATTERN_SELECT;
            irq_mask              <= tpd_pkg::RST_IRQ_MASK;
        end else if (wr_lane0 && wr_mapped) begin
            case (wr_idx)
                tpd_pkg::IDX_PATTERN_CONFIG:
                    pattern_detect_config <= w_data[7:0] & 8'h8F;
                tpd_pkg::IDX_PATTERN_SELECT:
                    pattern_select <= w_data[7:0];
                tpd_pkg::IDX_IRQ_MASK:
                    irq_mask <= w_data[tpd_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // write 0 to int bit clears once blocking is gone
    assign clear_int_req = wr_lane0 && wr_mapped
        && (wr_idx == tpd_pkg::IDX_MAIN_CONTROL)
        && !w_data[tpd_pkg::CTRL_INT_BIT] && !blocked;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pattern_event_flag <= 1'b0;
        end else if (ce) begin
            if (pattern_event) begin
                pattern_event_flag <= 1'b1;
            end else if (clear_int_req) begin
                pattern_event_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_bit <= 1'b0;
        end else if (ce) begin
            if (pattern_event && pattern_alert_enable) begin
                int_bit <= 1'b1;
            end else if (clear_int_req) begin
                int_bit <= 1'b0;
            end
        end
    end
    assign alert_n = !int_bit;
    // sticky interrupt status, write one to clear, set wins
    logic [tpd_pkg::IRQ_W-1:0] irq_set;
    logic [tpd_pkg::IRQ_W-1:0] irq_clr;

    always_comb begin
        irq_set = '0;
        irq_set[tpd_pkg::IRQ_PATTERN_BIT] = pattern_event;
        irq_set[tpd_pkg::IRQ_BASE_BIT]    =
            ce && base_count_range_summary && !base_summary_d;
        irq_clr = '0;
        if (wr_lane0 && wr_mapped && wr_idx == tpd_pkg::IDX_IRQ_STATUS) begin
            irq_clr = w_data[tpd_pkg::IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
        end else if (ce) begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end
    assign irq = |(irq_status & irq_mask);
    // read path
    always_comb begin
        next_rdata = '0;
        rd_mapped  = (s_axi_araddr[AW-1:10] == '0);
        case (rd_idx)
            tpd_pkg::IDX_MAIN_CONTROL:
                next_rdata[tpd_pkg::CTRL_INT_BIT] = int_bit;
            tpd_pkg::IDX_GENERAL_STATUS: begin
                next_rdata[tpd_pkg::GSTAT_PATTERN_BIT] = pattern_event_flag;
                next_rdata[tpd_pkg::GSTAT_BASE_BIT] =
                    base_count_range_summary;
            end
            tpd_pkg::IDX_PATTERN_CONFIG:
                next_rdata[7:0] = pattern_detect_config;
            tpd_pkg::IDX_PATTERN_SELECT:
                next_rdata[7:0] = pattern_select;
            tpd_pkg::IDX_BASE_LIMIT:
                next_rdata[7:0] = base_count_limit_flags;
            tpd_pkg::IDX_IRQ_STATUS:
                next_rdata[tpd_pkg::IRQ_W-1:0] = irq_status;
            tpd_pkg::IDX_IRQ_MASK:
                next_rdata[tpd_pkg::IRQ_W-1:0] = irq_mask;
            default:
                rd_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= tpd_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mapped ? next_rdata : 32'h0000_0000;
                s_axi_rresp  <= rd_mapped ? tpd_pkg::RESP_OKAY
                                          : tpd_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench of the detector
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, ce, in_standby;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, sense_cycle_done;
    logic [63:0] delta_count;
    logic [55:0] active_thresh;
    logic [6:0]  standby_thresh;
    logic [7:0]  noise_flag, standby_enabled, base_count_out_of_range;
    logic [7:0]  touch_detect_raw, touch_detect;
    logic        touch_blocked, alert_n, irq;
    int          error_cnt = 0, checks_done = 0;

    tpd_top u_tpd_top (
        .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .sense_cycle_done, .delta_count,
        .noise_flag, .active_thresh, .standby_thresh, .standby_enabled,
        .in_standby, .base_count_out_of_range, .touch_detect_raw,
        .touch_detect, .touch_blocked, .alert_n, .irq);
    tpd_front u_tpd_front (.aclk, .sense_cycle_done, .delta_count,
        .noise_flag);

    always #4 aclk = ~aclk;

    task automatic give_verdict;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] i, d,
                      input logic [1:0] r = tpd_pkg::RESP_OKAY);
        logic ta, tw, tb = 1'b0;
        int   n = 0;
        @(posedge aclk);
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!tb && n < 50) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            if (tb) chk(32'(s_axi_bresp), 32'(r));
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
            n++;
        end
        chk(32'(tb), 32'h1);
    endtask

    task automatic rd(input logic [7:0] i, e,
                      input logic [1:0] r = tpd_pkg::RESP_OKAY);
        logic ta, tr = 1'b0;
        int   n = 0;
        @(posedge aclk);
        s_axi_araddr <= {2'h0, i, 2'h0};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!tr && n < 50) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            if (tr) chk(s_axi_rdata, {24'h0, e});
            if (tr) chk(32'(s_axi_rresp), 32'(r));
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
            n++;
        end
        chk(32'(tr), 32'h1);
    endtask

    // program, pulse once, check blocking
    task automatic ev(input logic [7:0] cfg, sel, d, hm, nz,
                      input logic b);
        wr(tpd_pkg::IDX_PATTERN_CONFIG, cfg);
        wr(tpd_pkg::IDX_PATTERN_SELECT, sel);
        u_tpd_front.pulse(d, hm, nz);
        @(negedge aclk);
        chk(32'(touch_blocked), 32'(b));
    endtask

    task automatic t_reset;
        rd(tpd_pkg::IDX_PATTERN_CONFIG, 8'h00);
        rd(tpd_pkg::IDX_PATTERN_SELECT, 8'hFF);
        rd(tpd_pkg::IDX_BASE_LIMIT, 8'h00);
        rd(8'h3F, 8'h00, tpd_pkg::RESP_SLVERR);
        wr(8'h3F, 8'h55, tpd_pkg::RESP_SLVERR);
        u_tpd_front.pulse(8'hFF, 8'hFF, 8'h00);
        @(negedge aclk);
        chk(32'(touch_blocked), 32'h0);
    endtask

    task automatic t_regs;
        wr(tpd_pkg::IDX_PATTERN_CONFIG, 8'hFF);
        rd(tpd_pkg::IDX_PATTERN_CONFIG, 8'h8F);
        wr(tpd_pkg::IDX_PATTERN_SELECT, 8'hA5);
        rd(tpd_pkg::IDX_PATTERN_SELECT, 8'hA5);
        wr(tpd_pkg::IDX_BASE_LIMIT, 8'hFF);
        rd(tpd_pkg::IDX_BASE_LIMIT, 8'h00);
    endtask

    task automatic t_thresh;
        logic [7:0] s [4] = '{8'd8, 8'd16, 8'd24, 8'd64};
        logic [7:0] cf;
        for (int c = 0; c < 4; c++) begin
            cf = {4'h8, 2'(c), 2'h0};
            ev(cf, 8'h01, s[c], 8'h01, 8'h00, 1'b0);
            ev(cf, 8'h01, s[c] + 8'h01, 8'h01, 8'h00, 1'b1);
        end
        @(posedge aclk);
        in_standby <= 1'b1;
        ev(8'h84, 8'h01, 8'h04, 8'h01, 8'h00, 1'b0);
        ev(8'h84, 8'h01, 8'h05, 8'h01, 8'h00, 1'b1);
        @(posedge aclk);
        in_standby <= 1'b0;
    endtask

    task automatic t_modes;
        ev(8'h80, 8'h0F, 8'h50, 8'hE0, 8'h00, 1'b0);
        ev(8'h80, 8'h0F, 8'h50, 8'hE0, 8'h10, 1'b1);
        ev(8'h82, 8'h0F, 8'h50, 8'hF0, 8'h00, 1'b0);
        ev(8'h82, 8'h0F, 8'h50, 8'h07, 8'h08, 1'b1);
        ev(8'h82, 8'h03, 8'h50, 8'h01, 8'h00, 1'b0);
        ev(8'h82, 8'h03, 8'h50, 8'h02, 8'h00, 1'b0);
    endtask

    task automatic t_event;
        wr(tpd_pkg::IDX_MAIN_CONTROL, 8'h00);
        wr(tpd_pkg::IDX_IRQ_STATUS, 8'h03);
        wr(tpd_pkg::IDX_IRQ_MASK, 8'h01);
        rd(tpd_pkg::IDX_GENERAL_STATUS, 8'h00);
        ev(8'h81, 8'h01, 8'h09, 8'h01, 8'h00, 1'b1);
        @(negedge aclk);
        chk(32'(alert_n), 32'h0);
        chk(32'(irq), 32'h1);
        chk(32'(touch_detect), 32'h0);
        rd(tpd_pkg::IDX_GENERAL_STATUS, 8'h04);
        // clear ignored while pattern holds
        wr(tpd_pkg::IDX_MAIN_CONTROL, 8'h00);
        chk(32'(alert_n), 32'h0);
        ev(8'h81, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0);
        @(negedge aclk);
        chk(32'(touch_detect), 32'hFF);
        wr(tpd_pkg::IDX_MAIN_CONTROL, 8'h00);
        chk(32'(alert_n), 32'h1);
        rd(tpd_pkg::IDX_GENERAL_STATUS, 8'h00);
        wr(tpd_pkg::IDX_IRQ_STATUS, 8'h01);
        chk(32'(irq), 32'h0);
        ev(8'h80, 8'h01, 8'h09, 8'h01, 8'h00, 1'b1);
        chk(32'(alert_n), 32'h1);
        rd(tpd_pkg::IDX_GENERAL_STATUS, 8'h04);
    endtask

    task automatic t_base;
        @(posedge aclk);
        base_count_out_of_range <= 8'h81;
        wr(tpd_pkg::IDX_IRQ_MASK, 8'h02);
        rd(tpd_pkg::IDX_BASE_LIMIT, 8'h81);
        rd(tpd_pkg::IDX_GENERAL_STATUS, 8'h44);
        chk(32'(irq), 32'h1);
        @(posedge aclk);
        base_count_out_of_range <= 8'h00;
        wr(tpd_pkg::IDX_IRQ_STATUS, 8'h02);
        chk(32'(irq), 32'h0);
        rd(tpd_pkg::IDX_GENERAL_STATUS, 8'h04);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        in_standby = 1'b0;
        standby_enabled = 8'h01;
        active_thresh = {8{7'h40}};
        standby_thresh = 7'h10;
        base_count_out_of_range = 8'h00;
        touch_detect_raw = 8'hFF;
        s_axi_awaddr = '0;
        s_axi_araddr = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_regs;
        t_thresh;
        t_modes;
        t_event;
        t_base;
        give_verdict;
    end

    initial begin
        #100000;
        error_cnt++;
        give_verdict;
    end
endmodule

bind tpd_top tpd_chk #(.N(N)) u_tpd_chk (
    .aclk, .aresetn, .ce, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
    .sense_cycle_done, .touch_detect_raw, .touch_detect, .touch_blocked,
    .alert_n, .irq);
`default_nettype wire

/* sim/tpd_chk.sv */
// port assertions of the detector
`default_nettype none
module tpd_chk #(
    parameter int N = 8
) (
    // clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire logic         ce,
    // register bus handshakes
    input wire logic         s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic [31:0]  s_axi_rdata,
    input wire logic         s_axi_rvalid,
    input wire logic         s_axi_rready,
    input wire logic         s_axi_bvalid,
    input wire logic         s_axi_bready,
    // detection path
    input wire logic         sense_cycle_done,
    input wire logic [N-1:0] touch_detect_raw,
    input wire logic [N-1:0] touch_detect,
    input wire logic         touch_blocked,
    input wire logic         alert_n,
    input wire logic         irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_pulse;
        $past(ce && sense_cycle_done);
    endsequence
    sequence s_rtake;
        s_axi_arvalid && s_axi_arready && ce;
    endsequence
    a_alert_cause: assert property (
        $fell(alert_n) |-> s_pulse ##0 touch_blocked)
        else $error("alert without blocking cycle");
    a_block_change: assert property (
        $changed(touch_blocked) |-> s_pulse)
        else $error("blocking changed off cycle");
    a_blocked_quiet: assert property (
        touch_blocked && $past(touch_blocked) |-> touch_detect == '0)
        else $error("touch while blocked");
    a_detect_pass: assert property (
        !touch_blocked && !$past(touch_blocked) && $past(ce)
        && $past(aresetn) |-> touch_detect == $past(touch_detect_raw))
        else $error("touch not passed");
    a_irq_clear: assert property (
        $fell(irq) |-> s_axi_bvalid)
        else $error("irq fell without write");
    a_alert_clear: assert property (
        $rose(alert_n) |-> s_axi_bvalid)
        else $error("alert rose without write");
    a_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data unstable");
    a_read_answer: assert property (
        s_rtake |=> s_axi_rvalid)
        else $error("read not answered");
endmodule
`default_nettype wire

/* sim/tpd_front.sv */
// sensing front end model
`default_nettype none
module tpd_front (
    // clock
    input  wire logic        aclk,
    // sensing cycle results
    output var logic         sense_cycle_done,
    output var logic [63:0]  delta_count,
    output var logic [7:0]   noise_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {sense_cycle_done, delta_count, noise_flag} = '0;
    task automatic pulse(input logic [7:0] d, hm, nz);
        @(posedge aclk);
        for (int k = 0; k < 8; k++) begin
            delta_count[k*8 +: 8] <= hm[k] ? d : 8'h00;
        end
        noise_flag <= nz;
        sense_cycle_done <= 1'b1;
        @(posedge aclk);
        sense_cycle_done <= 1'b0;
        // scramble stale results
        delta_count <= ~delta_count;
        noise_flag <= ~noise_flag;
    endtask
endmodule
`default_nettype wire
